// *** hdl/nrf_pkg.sv ***
// Purpose: Shared constants and types of the node request filter.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes: All offsets are byte addresses.
package nrf_pkg;
   localparam int ADDR_W = 12;
   localparam int MASK_W = 32;
   localparam logic [ADDR_W-1:0] OFF_ASYNC_HI_SET = 12'h100;
   localparam logic [ADDR_W-1:0] OFF_ASYNC_HI_CLR = 12'h104;
   localparam logic [ADDR_W-1:0] OFF_ASYNC_LO_SET = 12'h108;
   localparam logic [ADDR_W-1:0] OFF_ASYNC_LO_CLR = 12'h10c;
   localparam logic [ADDR_W-1:0] OFF_PHYS_HI_SET = 12'h110;
   localparam logic [ADDR_W-1:0] OFF_PHYS_HI_CLR = 12'h114;
   localparam logic [MASK_W-1:0] MASK_RESET = 32'h00000000;
   localparam logic [MASK_W-1:0] MASK_NONE = 32'h00000000;
   localparam logic [MASK_W-1:0] MASK_ALL = 32'hffffffff;
   // Bits that a serial bus reset clears; the remote-bus bit survives.
   localparam logic [MASK_W-1:0] BUS_RST_CLR = 32'h7fffffff;
   localparam logic [4:0] REMOTE_BIT = 5'h1f;
   localparam logic [9:0] LOCAL_BUS_ID = 10'h3ff;
   localparam logic [5:0] NODE_BCAST = 6'h3f;
   localparam int NODE_UPPER_BIT = 5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_ASYNC_HI = 3'b001,
      SEL_ASYNC_LO = 3'b010,
      SEL_PHYS_HI = 3'b011
   } nrf_sel_t;

   typedef enum logic [0:0] {
      WR_COLLECT = 1'b0,
      WR_RESP = 1'b1
   } nrf_wr_st_t;

   typedef enum logic [0:0] {
      RD_IDLE = 1'b0,
      RD_DATA = 1'b1
   } nrf_rd_st_t;
endpackage

// *** hdl/nrf_req_if.sv ***
// Purpose: Carries a request and the masks to the filter, and its verdict back.
// Assumes: Everything here runs on the one block clock.
// Notes: The top drives requests and masks, the filter the verdict.
`timescale 1ns/1ps
`default_nettype none
interface nrf_req_if;
   logic reqValid;
   logic reqPhys;
   logic [9:0] srcBus;
   logic [5:0] srcNode;
   logic [9:0] localBus;
   logic [31:0] asyncLow;
   logic [31:0] asyncHigh;
   logic [31:0] physLow;
   logic [31:0] physHigh;
   logic decValid;
   logic decAck;
   logic decPhys;
   logic decArrq;
   modport filt (input reqValid, reqPhys, srcBus, srcNode, localBus,
      asyncLow, asyncHigh, physLow, physHigh,
      output decValid, decAck, decPhys, decArrq);
   modport top (output reqValid, reqPhys, srcBus, srcNode, localBus,
      asyncLow, asyncHigh, physLow, physHigh,
      input decValid, decAck, decPhys, decArrq);
endinterface
`default_nettype wire

// *** hdl/nrf_mask_reg.sv ***
// Purpose: One set/clear mask register.
// Assumes: Set and clear vectors are one-cycle pulses.
// Notes: A set in the same cycle as any clear wins.
`timescale 1ns/1ps
`default_nettype none
module nrf_mask_reg #(
   parameter int WIDTH = 32,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] setBits,
   input wire logic [WIDTH-1:0] clrBits,
   input wire logic [WIDTH-1:0] busRstClr,
   output logic [WIDTH-1:0] value
);
   typedef struct packed {
      logic [WIDTH-1:0] mask;
   } nrf_mask_st_t;

   nrf_mask_st_t state_r;
   nrf_mask_st_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      state_nxt.mask = (state_r.mask & ~clrBits & ~busRstClr) | setBits;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_r.mask <= RESET_VAL;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign value = state_r.mask;
endmodule
`default_nettype wire

// *** hdl/nrf_node_filter.sv ***
// Purpose: Decides acceptance and routing of one incoming request.
// Assumes: Request and masks are stable in the cycle reqValid is high.
// Notes: The verdict appears one clock after the request.
`timescale 1ns/1ps
`default_nettype none
module nrf_node_filter (
   input wire logic clock,
   input wire logic rst_b,
   nrf_req_if.filt rq
);
   typedef struct packed {
      logic valid;
      logic ack;
      logic toPhys;
      logic toArrq;
   } nrf_dec_st_t;

   nrf_dec_st_t state_r;
   nrf_dec_st_t state_nxt;

   always_comb begin
      logic isLocal;
      logic asyncOk;
      logic physOk;
      isLocal = 1'b0;
      asyncOk = 1'b0;
      physOk = 1'b0;
      state_nxt = state_r;
      isLocal = (rq.srcBus == nrf_pkg::LOCAL_BUS_ID) ||
         (rq.srcBus == rq.localBus);
      if (isLocal) begin
         if (!rq.srcNode[nrf_pkg::NODE_UPPER_BIT]) begin
            asyncOk = rq.asyncLow[rq.srcNode[4:0]];
            physOk = rq.physLow[rq.srcNode[4:0]];
         end else if (rq.srcNode != nrf_pkg::NODE_BCAST) begin
            asyncOk = rq.asyncHigh[rq.srcNode[4:0]];
            physOk = rq.physHigh[rq.srcNode[4:0]];
         end
      end else begin
         // Either remote-bus bit admits a foreign packet.
         asyncOk = rq.asyncHigh[nrf_pkg::REMOTE_BIT] |
            rq.physHigh[nrf_pkg::REMOTE_BIT];
         physOk = rq.physHigh[nrf_pkg::REMOTE_BIT];
      end
      state_nxt.valid = rq.reqValid;
      state_nxt.ack = rq.reqValid & asyncOk;
      state_nxt.toPhys = rq.reqValid & asyncOk & rq.reqPhys & physOk;
      state_nxt.toArrq = rq.reqValid & asyncOk &
         ~(rq.reqPhys & physOk);
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign rq.decValid = state_r.valid;
   assign rq.decAck = state_r.ack;
   assign rq.decPhys = state_r.toPhys;
   assign rq.decArrq = state_r.toArrq;
endmodule
`default_nettype wire

// *** hdl/nrf_node_request_filter.sv ***
// Purpose: Per-node receive request filter with its AXI4-Lite masks.
// Assumes: Request, bus reset and physical low mask share the clock.
// Notes: Every output of this module comes from a flip-flop.
//
// Function
// - Lower async mask bit n accepts async requests from node n.
// - Lower async mask: set 108h, clear 10Ch, resets to zero.
// - Upper physical mask: set 110h, clear 114h, resets to zero.
// - Accepted physical request with clear physical bit goes to async.
// - Upper physical bits 30..0 map to local nodes 62..32.
// - Per-node comparison applies only to sources on the local bus.
// - Remote-bus packets need bit 31 of either upper mask; physical routing needs the physical one.
// - Upper physical bit 31 survives a serial bus reset.
// - Local node with clear async bit: no acknowledge, no queueing.
// - Upper async mask covers nodes 62..32, bit 31 remote buses.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module nrf_node_request_filter (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [nrf_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [nrf_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serialBusReset,
   input wire logic [9:0] localBusId,
   input wire logic [31:0] physLowMask,
   input wire logic reqValid,
   input wire logic reqPhys,
   input wire logic [9:0] reqSrcBus,
   input wire logic [5:0] reqSrcNode,
   output logic decValid,
   output logic decAck,
   output logic decPhysCtx,
   output logic decArrqCtx
);
   typedef struct packed {
      nrf_pkg::nrf_wr_st_t wrSt;
      logic awReady;
      logic awHave;
      logic [nrf_pkg::ADDR_W-1:0] awAddr;
      logic wReady;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      nrf_pkg::nrf_rd_st_t rdSt;
      logic arReady;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } nrf_bus_st_t;

   nrf_bus_st_t state_r;
   nrf_bus_st_t state_nxt;

   logic [31:0] asyncLowVal;
   logic [31:0] asyncHighVal;
   logic [31:0] physHighVal;
   logic [31:0] asyncLowSet;
   logic [31:0] asyncLowClr;
   logic [31:0] asyncHighSet;
   logic [31:0] asyncHighClr;
   logic [31:0] physHighSet;
   logic [31:0] physHighClr;
   logic [31:0] physBusRstClr;
   logic doWrite;
   logic [31:0] wrBits;
   nrf_pkg::nrf_sel_t wrSel;
   logic wrIsSet;

   nrf_req_if rq();

   // Widens byte strobes into a bit mask.
   function automatic logic [31:0] strbMask(input logic [3:0] strb);
      logic [31:0] m;
      m = nrf_pkg::MASK_NONE;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   // Maps an address onto the mask it reaches.
   function automatic nrf_pkg::nrf_sel_t regSel(
      input logic [nrf_pkg::ADDR_W-1:0] addr
   );
      nrf_pkg::nrf_sel_t s;
      s = nrf_pkg::SEL_NONE;
      case (addr)
         nrf_pkg::OFF_ASYNC_HI_SET,
         nrf_pkg::OFF_ASYNC_HI_CLR: begin
            s = nrf_pkg::SEL_ASYNC_HI;
         end
         nrf_pkg::OFF_ASYNC_LO_SET,
         nrf_pkg::OFF_ASYNC_LO_CLR: begin
            s = nrf_pkg::SEL_ASYNC_LO;
         end
         nrf_pkg::OFF_PHYS_HI_SET,
         nrf_pkg::OFF_PHYS_HI_CLR: begin
            s = nrf_pkg::SEL_PHYS_HI;
         end
         default: begin
            s = nrf_pkg::SEL_NONE;
         end
      endcase
      return s;
   endfunction

   // Set addresses are the even words of each pair.
   function automatic logic isSetAddr(
      input logic [nrf_pkg::ADDR_W-1:0] addr
   );
      return (addr == nrf_pkg::OFF_ASYNC_HI_SET) ||
         (addr == nrf_pkg::OFF_ASYNC_LO_SET) ||
         (addr == nrf_pkg::OFF_PHYS_HI_SET);
   endfunction

   // The write is carried out in the cycle that raises the response.
   always_comb begin
      doWrite = (state_r.wrSt == nrf_pkg::WR_COLLECT) &&
         state_r.awHave && state_r.wHave;
      wrSel = regSel(state_r.awAddr);
      wrIsSet = isSetAddr(state_r.awAddr);
      wrBits = state_r.wData & strbMask(state_r.wStrb);
   end

   always_comb begin
      asyncLowSet = nrf_pkg::MASK_NONE;
      asyncLowClr = nrf_pkg::MASK_NONE;
      asyncHighSet = nrf_pkg::MASK_NONE;
      asyncHighClr = nrf_pkg::MASK_NONE;
      physHighSet = nrf_pkg::MASK_NONE;
      physHighClr = nrf_pkg::MASK_NONE;
      if (doWrite) begin
         case (wrSel)
            nrf_pkg::SEL_ASYNC_LO: begin
               if (wrIsSet) begin
                  asyncLowSet = wrBits;
               end else begin
                  asyncLowClr = wrBits;
               end
            end
            nrf_pkg::SEL_ASYNC_HI: begin
               if (wrIsSet) begin
                  asyncHighSet = wrBits;
               end else begin
                  asyncHighClr = wrBits;
               end
            end
            nrf_pkg::SEL_PHYS_HI: begin
               if (wrIsSet) begin
                  physHighSet = wrBits;
               end else begin
                  physHighClr = wrBits;
               end
            end
            default: begin
               asyncLowSet = nrf_pkg::MASK_NONE;
            end
         endcase
      end
   end

   // A bus reset drops upper-node physical routing but keeps the remote-bus bit.
   assign physBusRstClr = serialBusReset ? nrf_pkg::BUS_RST_CLR :
      nrf_pkg::MASK_NONE;

   nrf_mask_reg #(
      .WIDTH(nrf_pkg::MASK_W),
      .RESET_VAL(nrf_pkg::MASK_RESET)
   ) u_async_low (
      .clock(clock),
      .rst_b(rst_b),
      .setBits(asyncLowSet),
      .clrBits(asyncLowClr),
      .busRstClr(nrf_pkg::MASK_NONE),
      .value(asyncLowVal)
   );

   nrf_mask_reg #(
      .WIDTH(nrf_pkg::MASK_W),
      .RESET_VAL(nrf_pkg::MASK_RESET)
   ) u_async_high (
      .clock(clock),
      .rst_b(rst_b),
      .setBits(asyncHighSet),
      .clrBits(asyncHighClr),
      .busRstClr(nrf_pkg::MASK_NONE),
      .value(asyncHighVal)
   );

   nrf_mask_reg #(
      .WIDTH(nrf_pkg::MASK_W),
      .RESET_VAL(nrf_pkg::MASK_RESET)
   ) u_phys_high (
      .clock(clock),
      .rst_b(rst_b),
      .setBits(physHighSet),
      .clrBits(physHighClr),
      .busRstClr(physBusRstClr),
      .value(physHighVal)
   );

   assign rq.reqValid = reqValid;
   assign rq.reqPhys = reqPhys;
   assign rq.srcBus = reqSrcBus;
   assign rq.srcNode = reqSrcNode;
   assign rq.localBus = localBusId;
   assign rq.asyncLow = asyncLowVal;
   assign rq.asyncHigh = asyncHighVal;
   assign rq.physLow = physLowMask;
   assign rq.physHigh = physHighVal;

   nrf_node_filter u_filter (
      .clock(clock),
      .rst_b(rst_b),
      .rq(rq)
   );

   always_comb begin
      nrf_pkg::nrf_sel_t rdSel;
      rdSel = nrf_pkg::SEL_NONE;
      state_nxt = state_r;
      // Write address and data are taken in either order.
      if (state_r.awReady && s_axi_awvalid) begin
         state_nxt.awReady = 1'b0;
         state_nxt.awHave = 1'b1;
         state_nxt.awAddr = s_axi_awaddr;
      end
      if (state_r.wReady && s_axi_wvalid) begin
         state_nxt.wReady = 1'b0;
         state_nxt.wHave = 1'b1;
         state_nxt.wData = s_axi_wdata;
         state_nxt.wStrb = s_axi_wstrb;
      end
      case (state_r.wrSt)
         nrf_pkg::WR_COLLECT: begin
            if (doWrite) begin
               state_nxt.wrSt = nrf_pkg::WR_RESP;
               state_nxt.awHave = 1'b0;
               state_nxt.wHave = 1'b0;
               state_nxt.bValid = 1'b1;
               state_nxt.bResp = (wrSel == nrf_pkg::SEL_NONE) ?
                  nrf_pkg::RESP_SLVERR : nrf_pkg::RESP_OKAY;
            end
         end
         nrf_pkg::WR_RESP: begin
            if (s_axi_bready) begin
               state_nxt.wrSt = nrf_pkg::WR_COLLECT;
               state_nxt.bValid = 1'b0;
               state_nxt.awReady = 1'b1;
               state_nxt.wReady = 1'b1;
            end
         end
         default: begin
            state_nxt.wrSt = nrf_pkg::WR_COLLECT;
         end
      endcase
      // Either address of a pair reads back the same mask.
      case (state_r.rdSt)
         nrf_pkg::RD_IDLE: begin
            if (s_axi_arvalid) begin
               rdSel = regSel(s_axi_araddr);
               state_nxt.rdSt = nrf_pkg::RD_DATA;
               state_nxt.arReady = 1'b0;
               state_nxt.rValid = 1'b1;
               state_nxt.rResp = nrf_pkg::RESP_OKAY;
               case (rdSel)
                  nrf_pkg::SEL_ASYNC_LO: begin
                     state_nxt.rData = asyncLowVal;
                  end
                  nrf_pkg::SEL_ASYNC_HI: begin
                     state_nxt.rData = asyncHighVal;
                  end
                  nrf_pkg::SEL_PHYS_HI: begin
                     state_nxt.rData = physHighVal;
                  end
                  default: begin
                     state_nxt.rData = nrf_pkg::READ_UNMAPPED;
                     state_nxt.rResp = nrf_pkg::RESP_SLVERR;
                  end
               endcase
            end
         end
         nrf_pkg::RD_DATA: begin
            if (s_axi_rready) begin
               state_nxt.rdSt = nrf_pkg::RD_IDLE;
               state_nxt.rValid = 1'b0;
               state_nxt.arReady = 1'b1;
            end
         end
         default: begin
            state_nxt.rdSt = nrf_pkg::RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_r.wrSt <= nrf_pkg::WR_COLLECT;
         state_r.awReady <= 1'b1;
         state_r.awHave <= 1'b0;
         state_r.awAddr <= '0;
         state_r.wReady <= 1'b1;
         state_r.wHave <= 1'b0;
         state_r.wData <= '0;
         state_r.wStrb <= '0;
         state_r.bValid <= 1'b0;
         state_r.bResp <= nrf_pkg::RESP_OKAY;
         state_r.rdSt <= nrf_pkg::RD_IDLE;
         state_r.arReady <= 1'b1;
         state_r.rValid <= 1'b0;
         state_r.rData <= '0;
         state_r.rResp <= nrf_pkg::RESP_OKAY;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign s_axi_awready = state_r.awReady;
   assign s_axi_wready = state_r.wReady;
   assign s_axi_bvalid = state_r.bValid;
   assign s_axi_bresp = state_r.bResp;
   assign s_axi_arready = state_r.arReady;
   assign s_axi_rvalid = state_r.rValid;
   assign s_axi_rdata = state_r.rData;
   assign s_axi_rresp = state_r.rResp;
   assign decValid = rq.decValid;
   assign decAck = rq.decAck;
   assign decPhysCtx = rq.decPhys;
   assign decArrqCtx = rq.decArrq;
endmodule
`default_nettype wire

// *** dv/nrf_node_src.sv ***
// Purpose: Model of remote serial bus nodes sending request packets.
// Assumes: One request per call, held for exactly one clock.
// Notes: Idle request fields are zero before the first call, then show inverted last values.
`timescale 1ns/1ps
`default_nettype none
module nrf_node_src (
   input wire logic clock,
   output logic reqValid,
   output logic reqPhys,
   output logic [9:0] reqSrcBus,
   output logic [5:0] reqSrcNode
);
   initial begin
      reqValid = 1'b0;
      reqPhys = 1'b0;
      reqSrcBus = 10'h000;
      reqSrcNode = 6'h00;
   end

   // A filter that peeks at idle fields would see garbage, not a match.
   task automatic send(input logic phys, input logic [9:0] bus,
      input logic [5:0] node);
      @(posedge clock);
      reqValid <= 1'b1;
      reqPhys <= phys;
      reqSrcBus <= bus;
      reqSrcNode <= node;
      @(posedge clock);
      reqValid <= 1'b0;
      reqPhys <= ~phys;
      reqSrcBus <= ~bus;
      reqSrcNode <= ~node;
   endtask
endmodule
`default_nettype wire

// *** dv/nrf_node_request_filter_sva.sv ***
// Purpose: Port-level checks of the node request filter.
// Assumes: One clock, synchronous active-low reset.
// Notes: Mask contents are judged by the bench through register reads.
`timescale 1ns/1ps
`default_nettype none
module nrf_node_request_filter_sva (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic reqValid,
   input wire logic reqPhys,
   input wire logic [9:0] reqSrcBus,
   input wire logic [5:0] reqSrcNode,
   input wire logic [9:0] localBusId,
   input wire logic [31:0] physLowMask,
   input wire logic decValid,
   input wire logic decAck,
   input wire logic decPhysCtx,
   input wire logic decArrqCtx
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire logic localSrc;
   assign localSrc = (reqSrcBus == localBusId) ||
      (reqSrcBus == nrf_pkg::LOCAL_BUS_ID);

   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_answer;
      ##[1:3] s_axi_bvalid;
   endsequence

   property p_wr_resp;
      s_wr_taken |-> s_wr_answer;
   endproperty
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   property p_aw_drop;
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
   endproperty
   property p_dec_time;
      reqValid |=> decValid;
   endproperty
   property p_dec_idle;
      !reqValid |=> !decValid && !decAck && !decPhysCtx && !decArrqCtx;
   endproperty
   property p_route_one;
      decValid |-> (decAck == (decPhysCtx ^ decArrqCtx));
   endproperty
   property p_async_no_phys;
      reqValid && !reqPhys |=> !decPhysCtx;
   endproperty
   property p_low_phys;
      reqValid && localSrc && !reqSrcNode[5] &&
         !physLowMask[reqSrcNode[4:0]] |=> !decPhysCtx;
   endproperty
   property p_node_top;
      reqValid && localSrc && reqSrcNode == 6'h3f |=> !decAck;
   endproperty

   a_wr_resp: assert property (p_wr_resp)
      else $error("write response missing");
   a_rd_resp: assert property (p_rd_resp)
      else $error("read data missing");
   a_aw_drop: assert property (p_aw_drop)
      else $error("second write address taken");
   a_dec_time: assert property (p_dec_time)
      else $error("verdict late");
   a_dec_idle: assert property (p_dec_idle)
      else $error("verdict without request");
   a_route_one: assert property (p_route_one)
      else $error("routing not one context");
   a_async_no_phys: assert property (p_async_no_phys)
      else $error("async request routed physical");
   a_low_phys: assert property (p_low_phys)
      else $error("physical route with clear low bit");
   a_node_top: assert property (p_node_top)
      else $error("node above 62 accepted");
endmodule
`default_nettype wire

bind nrf_node_request_filter nrf_node_request_filter_sva nrf_sva_i (
   .clock(clock), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .reqValid(reqValid), .reqPhys(reqPhys),
   .reqSrcBus(reqSrcBus), .reqSrcNode(reqSrcNode),
   .localBusId(localBusId), .physLowMask(physLowMask),
   .decValid(decValid), .decAck(decAck), .decPhysCtx(decPhysCtx),
   .decArrqCtx(decArrqCtx));

// *** dv/nrf_node_request_filter_tb.sv ***
// Purpose: Self-checking bench of the node request filter.
// Assumes: Local bus number 001h; remote traffic uses bus 005h.
// Notes: Verdict codes are {accept, physical, async receive}.
`timescale 1ns/1ps
`default_nettype none
module nrf_node_request_filter_tb;
   localparam logic [2:0] REJ = 3'b000;
   localparam logic [2:0] ARQ = 3'b101;
   localparam logic [2:0] PHY = 3'b110;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [11:0] awAddr = 12'h000, arAddr = 12'h000;
   logic [31:0] wData = 32'h0, physLow = 32'h0, rData;
   logic [3:0] wStrb = 4'hf;
   logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
   logic arValid = 1'b0, rReady = 1'b0, busRst = 1'b0;
   logic awReady, wReady, bValid, arReady, rValid;
   logic dValid, dAck, dPhys, dArrq, reqValid, reqPhys;
   logic [1:0] bResp, rResp;
   logic [9:0] localBus = 10'h001, reqBus;
   logic [5:0] reqNode;
   int error_cnt = 0;
   int total_checks = 0;
   logic [11:0] offs [6] = '{nrf_pkg::OFF_ASYNC_HI_SET,
      nrf_pkg::OFF_ASYNC_HI_CLR, nrf_pkg::OFF_ASYNC_LO_SET,
      nrf_pkg::OFF_ASYNC_LO_CLR, nrf_pkg::OFF_PHYS_HI_SET,
      nrf_pkg::OFF_PHYS_HI_CLR};

   always #50 clock = ~clock;

   nrf_node_src nrf_node_src_i (.clock(clock), .reqValid(reqValid),
      .reqPhys(reqPhys), .reqSrcBus(reqBus), .reqSrcNode(reqNode));

   nrf_node_request_filter nrf_node_request_filter_i (.clock(clock),
      .rst_b(rst_b), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .serialBusReset(busRst),
      .localBusId(localBus), .physLowMask(physLow), .reqValid(reqValid),
      .reqPhys(reqPhys), .reqSrcBus(reqBus), .reqSrcNode(reqNode),
      .decValid(dValid), .decAck(dAck), .decPhysCtx(dPhys),
      .decArrqCtx(dArrq));

   task automatic stop_test();
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Write; address and data are offered together and dropped as taken.
   // Only the watchdog ends a wait for an answer that never comes.
   task automatic wrc(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] e);
      @(posedge clock);
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do begin
         @(posedge clock);
         if (awValid && awReady) awValid <= 1'b0;
         if (wValid && wReady) wValid <= 1'b0;
      end while (!(bValid && bReady));
      bReady <= 1'b0;
      chk({30'h0, bResp}, {30'h0, e});
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] e);
      @(posedge clock);
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      do begin
         @(posedge clock);
         if (arValid && arReady) arValid <= 1'b0;
      end while (!(rValid && rReady));
      rReady <= 1'b0;
      chk(rData, d);
      chk({30'h0, rResp}, {30'h0, e});
   endtask

   // The verdict lands on the edge that takes the request; look just after.
   task automatic rq(input logic phys, input logic [9:0] bus,
      input logic [5:0] node, input logic [2:0] e);
      nrf_node_src_i.send(phys, bus, node);
      #1;
      chk({28'h0, dValid, dAck, dPhys, dArrq}, {28'h0, 1'b1, e});
   endtask

   initial begin
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      foreach (offs[i]) rdc(offs[i], 32'h0, nrf_pkg::RESP_OKAY);
      rdc(12'h120, nrf_pkg::READ_UNMAPPED, nrf_pkg::RESP_SLVERR);
      wrc(12'h120, 32'hffffffff, nrf_pkg::RESP_SLVERR);
      rq(1'b0, 10'h001, 6'd31, REJ);
      wrc(nrf_pkg::OFF_ASYNC_LO_SET, 32'h80000001, nrf_pkg::RESP_OKAY);
      rdc(nrf_pkg::OFF_ASYNC_LO_CLR, 32'h80000001, nrf_pkg::RESP_OKAY);
      wrc(nrf_pkg::OFF_ASYNC_LO_CLR, 32'h00000001, nrf_pkg::RESP_OKAY);
      rdc(nrf_pkg::OFF_ASYNC_LO_SET, 32'h80000000, nrf_pkg::RESP_OKAY);
      rq(1'b0, 10'h001, 6'd31, ARQ);
      rq(1'b1, 10'h3ff, 6'd0, REJ);
      rq(1'b1, 10'h001, 6'd31, ARQ);
      @(posedge clock);
      physLow <= 32'h80000000;
      rq(1'b1, 10'h001, 6'd31, PHY);
      rq(1'b1, 10'h001, 6'd63, REJ);
      wrc(nrf_pkg::OFF_ASYNC_HI_SET, 32'h40000001, nrf_pkg::RESP_OKAY);
      wrc(nrf_pkg::OFF_PHYS_HI_SET, 32'h40000000, nrf_pkg::RESP_OKAY);
      rq(1'b1, 10'h001, 6'd62, PHY);
      rq(1'b1, 10'h001, 6'd32, ARQ);
      rq(1'b0, 10'h005, 6'd31, REJ);
      rq(1'b0, 10'h005, 6'd62, REJ);
      wrc(nrf_pkg::OFF_PHYS_HI_SET, 32'h80000000, nrf_pkg::RESP_OKAY);
      rdc(nrf_pkg::OFF_PHYS_HI_CLR, 32'hc0000000, nrf_pkg::RESP_OKAY);
      rq(1'b1, 10'h005, 6'd2, PHY);
      rq(1'b0, 10'h005, 6'd2, ARQ);
      @(posedge clock);
      busRst <= 1'b1;
      @(posedge clock);
      busRst <= 1'b0;
      rdc(nrf_pkg::OFF_PHYS_HI_SET, 32'h80000000, nrf_pkg::RESP_OKAY);
      rq(1'b1, 10'h001, 6'd62, ARQ);
      wrc(nrf_pkg::OFF_PHYS_HI_CLR, 32'h80000000, nrf_pkg::RESP_OKAY);
      rq(1'b0, 10'h005, 6'd7, REJ);
      wrc(nrf_pkg::OFF_ASYNC_HI_SET, 32'h80000000, nrf_pkg::RESP_OKAY);
      rq(1'b1, 10'h005, 6'd7, ARQ);
      // Only the top byte lane acts, so node 32 keeps its bit.
      wStrb <= 4'h8;
      wrc(nrf_pkg::OFF_ASYNC_HI_CLR, 32'hc0000001, nrf_pkg::RESP_OKAY);
      wStrb <= 4'hf;
      rdc(nrf_pkg::OFF_ASYNC_HI_SET, 32'h00000001, nrf_pkg::RESP_OKAY);
      rq(1'b0, 10'h005, 6'd7, REJ);
      rq(1'b0, 10'h001, 6'd32, ARQ);
      stop_test();
   end

   // The sequence needs under two hundred cycles; this allows 5000.
   initial begin
      #(100 * 5000);
      error_cnt++;
      stop_test();
   end
endmodule
`default_nettype wire
